// ===== dv/sfps_host.sv
// Serial host model that drives select, clock and data in.
`timescale 1ns/1ps
`default_nettype none
module sfps_host (
	output logic      chip_select_n,
	output logic      sck,
	output logic      si,
	input  wire logic so
);
	localparam int HALF = 160;

	initial begin
		chip_select_n = 1'b1;
		sck           = 1'b0;
		si            = 1'b0;
	end

	task automatic frame(input logic [47:0] tx, input int nbits,
		output logic [7:0] rx);
		rx = '0;
		#13 chip_select_n = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			si = tx[47-i];
			#HALF sck = 1'b1;
			#HALF rx = {rx[6:0], so};
			sck = 1'b0;
		end
		// select rises in the clock low time
		#HALF chip_select_n = 1'b1;
		si = ~si;
	endtask
endmodule // sfps_host
`default_nettype wire

// ===== dv/sfps_props.sv
// Port checker for the flash protect and signature block.
`timescale 1ns/1ps
`default_nettype none
module sfps_props #(
	parameter int PWRUP_CYCLES   = 20,
	parameter int SLEEP_CYCLES   = 10,
	parameter int RELEASE_CYCLES = 10
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic chip_select_n,
	input wire logic sck,
	input wire logic si,
	input wire logic cycle_busy,
	input wire logic wel_clear,
	input wire logic so,
	input wire logic so_oe_n,
	input wire logic protected_mode,
	input wire logic standby,
	input wire logic cmd_enable,
	input wire logic write_in_progress,
	input wire logic write_enable_latch
);
	logic [10:0] up_cnt_r;
	logic [7:0]  hi_cnt_r;
	logic [3:0]  age_r;
	logic        sck_r;

	// Counts up-time, select-high time and time since a serial clock fall.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			up_cnt_r <= '0;
			hi_cnt_r <= '0;
			age_r    <= 4'hf;
			sck_r    <= 1'b0;
		end else begin
			sck_r    <= sck;
			up_cnt_r <= (&up_cnt_r) ? up_cnt_r : up_cnt_r + 11'h1;
			hi_cnt_r <= !chip_select_n ? 8'h0 :
				(&hi_cnt_r) ? hi_cnt_r : hi_cnt_r + 8'h1;
			age_r    <= (sck_r && !sck) ? 4'h0 :
				(&age_r) ? age_r : age_r + 4'h1;
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);

	sequence s_cs_idle;
		chip_select_n [*6];
	endsequence

	chk_pwrup_gate: assert property (
		cmd_enable |-> up_cnt_r >= PWRUP_CYCLES) else $error("early enable");
	chk_pwrup_state: assert property (
		up_cnt_r < PWRUP_CYCLES |-> !protected_mode && !write_enable_latch)
		else $error("bad power-up state");
	chk_sleep_delay: assert property (
		$rose(protected_mode) |-> hi_cnt_r >= SLEEP_CYCLES &&
		hi_cnt_r <= SLEEP_CYCLES + 8) else $error("sleep entry timing");
	chk_release_delay: assert property (
		$fell(protected_mode) |-> hi_cnt_r >= RELEASE_CYCLES &&
		hi_cnt_r <= RELEASE_CYCLES + 8) else $error("release timing");
	chk_prot_excl: assert property (
		protected_mode |-> !cmd_enable && !standby) else $error("mode clash");
	chk_so_idle: assert property (
		s_cs_idle |-> so_oe_n) else $error("output driven when idle");
	chk_so_edge: assert property (
		!so_oe_n && !$past(so_oe_n) && $changed(so) |-> age_r <= 6)
		else $error("output moved off a clock fall");
	chk_wip_busy: assert property (
		cycle_busy [*5] |-> write_in_progress) else $error("busy not shown");
	chk_wip_idle: assert property (
		!cycle_busy [*5] |-> !write_in_progress) else $error("stale busy");
	chk_wel_clear: assert property (
		wel_clear |=> !write_enable_latch) else $error("latch not cleared");
endmodule // sfps_props

bind sfps_top sfps_props #(.PWRUP_CYCLES(PWRUP_CYCLES),
	.SLEEP_CYCLES(SLEEP_CYCLES), .RELEASE_CYCLES(RELEASE_CYCLES)) i_props (
	.clock, .nrst, .chip_select_n, .sck, .si, .cycle_busy, .wel_clear,
	.so, .so_oe_n, .protected_mode, .standby, .cmd_enable,
	.write_in_progress, .write_enable_latch);
`default_nettype wire

// ===== dv/sfps_top_tb.sv
// Self-checking bench for the flash protect and signature block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("ERROR %s exp %h got %h", nm, e, g); end end
module sfps_top_tb;
	localparam int         PU = 200;
	localparam int         SL = 10;
	localparam logic [7:0] P  = sfps_pkg::OP_PROTECT;
	localparam logic [7:0] PD = sfps_pkg::OP_POWERDOWN;
	localparam logic [7:0] RS = sfps_pkg::OP_RELEASE;
	localparam logic [7:0] SG = sfps_pkg::SIGNATURE;
	logic       clock;
	logic       nrst;
	logic       cycle_busy;
	logic       wel_clear;
	wire        chip_select_n;
	wire        sck;
	wire        si;
	logic       so;
	logic       so_oe_n;
	logic       protected_mode;
	logic       standby;
	logic       cmd_enable;
	logic       write_in_progress;
	logic       write_enable_latch;
	int         n_fail;
	int         num_checks;
	int         m_prot;
	int         m_ready;
	logic [7:0] rx;
	logic [7:0] op;

	sfps_top #(.PWRUP_CYCLES(PU), .SLEEP_CYCLES(SL), .RELEASE_CYCLES(SL))
	i_dut (.clock(clock), .nrst(nrst), .chip_select_n(chip_select_n),
		.sck(sck), .si(si), .cycle_busy(cycle_busy), .wel_clear(wel_clear),
		.so(so), .so_oe_n(so_oe_n), .protected_mode(protected_mode),
		.standby(standby), .cmd_enable(cmd_enable),
		.write_in_progress(write_in_progress),
		.write_enable_latch(write_enable_latch));
	sfps_host i_host (.chip_select_n(chip_select_n), .sck(sck), .si(si),
		.so(so));

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	task automatic give_verdict();
		if (n_fail == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic do_reset();
		@(negedge clock) nrst = 1'b0;
		repeat (10) @(negedge clock);
		nrst    = 1'b1;
		m_prot  = 0;
		m_ready = 0;
	endtask

	task automatic cmd(input logic [7:0] o, input int nb);
		i_host.frame({o, 40'h0}, nb, rx);
		if (m_ready != 0 && !cycle_busy) begin
			if (o == RS) m_prot = 0;
			else if ((o == P || o == PD) && nb == 8) m_prot = 1;
		end
		@(negedge clock) wel_clear = 1'($urandom());
		@(negedge clock) wel_clear = 1'b0;
		repeat (3 * SL + 20) @(negedge clock);
		`CHK("protected_mode", m_prot[0], protected_mode)
		`CHK("write_enable_latch", 1'b0, write_enable_latch)
		if (m_ready != 0 && !cycle_busy) `CHK("standby", !m_prot[0], standby)
	endtask

	initial begin
		#1000000;
		n_fail++;
		give_verdict();
	end

	initial begin
		nrst       = 1'b0;
		cycle_busy = 1'b0;
		wel_clear  = 1'b0;
		n_fail     = 0;
		num_checks = 0;
		void'($urandom(32'h67116ab1));
		do_reset();
		`CHK("so_oe_n", 1'b1, so_oe_n)
		`CHK("cmd_enable", 1'b0, cmd_enable)
		// protect opcode sent before the power-up delay is ignored
		cmd(P, 8);
		repeat (PU) @(negedge clock);
		m_ready = 1;
		`CHK("cmd_enable", 1'b1, cmd_enable)
		for (int k = 0; k < 2; k++) begin
			cmd(k ? PD : P, 8);
			op = 8'($urandom());
			if (op == RS) op = ~op;
			cmd(op, 8);
			cmd(RS, 8);
		end
		cmd(P, 9);
		cmd(RS, 40);
		`CHK("signature", SG, rx)
		cmd(RS, 48);
		`CHK("signature repeat", SG, rx)
		cmd(P, 8);
		cmd(RS, 40);
		`CHK("signature", SG, rx)
		@(negedge clock) cycle_busy = 1'b1;
		repeat (10) @(negedge clock);
		`CHK("write_in_progress", 1'b1, write_in_progress)
		cmd(P, 8);
		cycle_busy = 1'b0;
		cmd(P, 8);
		cycle_busy = 1'b1;
		repeat (10) @(negedge clock);
		cmd(RS, 40);
		cycle_busy = 1'b0;
		repeat (10) @(negedge clock);
		`CHK("write_in_progress", 1'b0, write_in_progress)
		cmd(RS, 8);
		cmd(P, 8);
		do_reset();
		`CHK("protected_mode", 1'b0, protected_mode)
		give_verdict();
	end
endmodule // sfps_top_tb
`default_nettype wire

// ===== hw/sfps_delay.sv
// Down counter that raises done a set number of cycles after start.
`timescale 1ns/1ps
`default_nettype none
module sfps_delay #(
	parameter int W = 17
) (
	input  wire logic         clock,
	input  wire logic         nrst,
	input  wire logic         start,
	input  wire logic [W-1:0] cycles,
	output logic              busy,
	output logic              done
);
	logic [W-1:0] cnt_r;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cnt_r <= '0;
		end else if (start) begin
			cnt_r <= cycles;
		end else if (cnt_r != '0) begin
			cnt_r <= cnt_r - 1'b1;
		end
	end

	assign busy = (cnt_r != '0);
	assign done = (cnt_r == {{(W-1){1'b0}}, 1'b1});
endmodule // sfps_delay
`default_nettype wire

// ===== hw/sfps_link_sync.sv
// Pin synchroniser and edge finder for the serial link.
`timescale 1ns/1ps
`default_nettype none
module sfps_link_sync (
	input  wire logic               clock,
	input  wire logic               nrst,
	input  wire logic               chip_select_n,
	input  wire logic               sck,
	input  wire logic               si,
	output sfps_pkg::sfps_link_t    link
);
	logic [2:0] m1_r;
	logic [2:0] m2_r;
	logic [1:0] prev_r;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			m1_r   <= 3'h1;
			m2_r   <= 3'h1;
			prev_r <= 2'h1;
		end else begin
			m1_r   <= {si, sck, chip_select_n};
			m2_r   <= m1_r;
			prev_r <= m2_r[1:0];
		end
	end

	assign link.sck_rise = m2_r[1] & ~prev_r[1];
	assign link.sck_fall = ~m2_r[1] & prev_r[1];
	assign link.cs_rise  = m2_r[0] & ~prev_r[0];
	assign link.cs_low   = ~m2_r[0];
	assign link.si       = m2_r[2];
endmodule // sfps_link_sync
`default_nettype wire

// ===== hw/sfps_pkg.sv
// Package of constants, states and carriers for the flash protect/signature block.
package sfps_pkg;

	localparam int          CLK_PERIOD_NS    = 40;
	// Power-up delay in microseconds (2 ms).
	localparam int          PWRUP_DELAY_US   = 2000;
	localparam int          PWRUP_CYCLES     = (PWRUP_DELAY_US * 1000) / CLK_PERIOD_NS;
	// Sleep-entry and release delays in nanoseconds; plain defaults.
	localparam int          SLEEP_DELAY_NS   = 3000;
	localparam int          SLEEP_CYCLES     = (SLEEP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          RELEASE_DELAY_NS = 3000;
	localparam int          RELEASE_CYCLES   = (RELEASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Opcode values are plain defaults; set them to suit the host.
	localparam logic [7:0]  OP_PROTECT       = 8'h3c;
	localparam logic [7:0]  OP_POWERDOWN     = 8'h3d;
	localparam logic [7:0]  OP_RELEASE       = 8'h4e;
	// Signature value is arbitrary.
	localparam logic [7:0]  SIGNATURE        = 8'h5a;
	localparam int          DUMMY_BYTES      = 3;

	typedef enum logic [1:0] {
		SFPS_PWRUP,
		SFPS_STANDBY,
		SFPS_PROTECTED
	} sfps_mode_t;

	typedef struct packed {
		logic sck_rise;
		logic sck_fall;
		logic cs_rise;
		logic cs_low;
		logic si;
	} sfps_link_t;

endpackage

// ===== hw/sfps_top.sv
// Protect, release and signature logic of a serial flash slave.
// Function
// - Deep power-down opcode behaves exactly like the software-protect opcode.
// - Protect executes only if chip select rises right after bit eight.
// - Protected state is entered a sleep-entry delay after chip select rises.
// - While protected only the release opcode is decoded; it ends protection.
// - Protection clears on power loss; power-up lands in standby.
// - Protect received during a busy internal cycle is rejected.
// - Release received during a busy internal cycle is not decoded.
// - Release opcode is eight bits sampled on rising clock edges.
// - Chip select rising after the opcode, before signature, still releases.
// - Standby is reached a release delay after chip select rises.
// - Signature shifts out on falling clock edges after the dummy bytes.
// - A fixed eight-bit signature is readable only through release.
// - Release returns the signature even outside the protected state.
// - Extra clocks with chip select low repeat the signature byte.
// - Chip select rising after a full signature ends release to standby.
// - Power-on reset holds all logic reset and answers nothing.
// - All commands are ignored until the power-up delay elapses.
// - Power-up ends in standby with the write-enable latch cleared.
// - Write-in-progress reads one during a busy cycle, zero after.
`timescale 1ns/1ps
`default_nettype none
module sfps_top #(
	parameter logic [7:0] OP_PROTECT     = sfps_pkg::OP_PROTECT,
	parameter logic [7:0] OP_POWERDOWN   = sfps_pkg::OP_POWERDOWN,
	parameter logic [7:0] OP_RELEASE     = sfps_pkg::OP_RELEASE,
	parameter logic [7:0] SIGNATURE      = sfps_pkg::SIGNATURE,
	parameter int         PWRUP_CYCLES   = sfps_pkg::PWRUP_CYCLES,
	parameter int         SLEEP_CYCLES   = sfps_pkg::SLEEP_CYCLES,
	parameter int         RELEASE_CYCLES = sfps_pkg::RELEASE_CYCLES
) (
	input  wire logic clock,
	input  wire logic nrst,
	input  wire logic chip_select_n,
	input  wire logic sck,
	input  wire logic si,
	input  wire logic cycle_busy,
	input  wire logic wel_clear,
	output logic      so,
	output logic      so_oe_n,
	output logic      protected_mode,
	output logic      standby,
	output logic      cmd_enable,
	output logic      write_in_progress,
	output logic      write_enable_latch
);
	localparam int DW = 17;

	sfps_pkg::sfps_link_t link;
	sfps_pkg::sfps_mode_t mode_r;

	logic [7:0]  shift_r;
	logic [5:0]  bitcnt_r;
	logic        is_prot_r;
	logic        is_rel_r;
	logic        ignore_r;
	logic        sig_done_r;
	logic [2:0]  sigbit_r;
	logic        out_en_r;
	logic        so_r;
	logic        pend_sleep_r;
	logic        pend_rel_r;
	logic        busy_m1_r;
	logic        busy_r;
	logic        pu_busy;
	logic        pu_done;
	logic        sl_busy;
	logic        sl_done;
	logic        rl_busy;
	logic        rl_done;
	logic        pu_start_r;
	logic        prot_arm;
	logic        rel_arm;
	logic [7:0]  opcode_nxt;

	function automatic logic is_protect_op(input logic [7:0] op);
		// Both opcodes map onto one action.
		return (op == OP_PROTECT) || (op == OP_POWERDOWN);
	endfunction

	sfps_link_sync u_sync (
		.clock         (clock),
		.nrst          (nrst),
		.chip_select_n (chip_select_n),
		.sck           (sck),
		.si            (si),
		.link          (link)
	);

	// Busy comes from another engine, possibly asynchronous; synchronise it.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			busy_m1_r <= 1'b0;
			busy_r    <= 1'b0;
		end else begin
			busy_m1_r <= cycle_busy;
			busy_r    <= busy_m1_r;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pu_start_r <= 1'b1;
		end else begin
			pu_start_r <= 1'b0;
		end
	end

	sfps_delay #(.W(DW)) u_pwrup (
		.clock  (clock),
		.nrst   (nrst),
		.start  (pu_start_r),
		.cycles (DW'(PWRUP_CYCLES)),
		.busy   (pu_busy),
		.done   (pu_done)
	);

	sfps_delay #(.W(DW)) u_sleep (
		.clock  (clock),
		.nrst   (nrst),
		.start  (prot_arm),
		.cycles (DW'(SLEEP_CYCLES)),
		.busy   (sl_busy),
		.done   (sl_done)
	);

	sfps_delay #(.W(DW)) u_release (
		.clock  (clock),
		.nrst   (nrst),
		.start  (rel_arm),
		.cycles (DW'(RELEASE_CYCLES)),
		.busy   (rl_busy),
		.done   (rl_done)
	);

	assign opcode_nxt = {shift_r[6:0], link.si};

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			shift_r  <= 8'h00;
			bitcnt_r <= 6'h00;
		end else if (!link.cs_low) begin
			bitcnt_r <= 6'h00;
		end else if (link.sck_rise && bitcnt_r != 6'h3f) begin
			shift_r  <= opcode_nxt;
			bitcnt_r <= bitcnt_r + 6'h01;
		end
	end

	// Decode at the eighth bit; frames during power-up are ignored.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			is_prot_r <= 1'b0;
			is_rel_r  <= 1'b0;
			ignore_r  <= 1'b0;
		end else if (!link.cs_low) begin
			is_prot_r <= 1'b0;
			is_rel_r  <= 1'b0;
			ignore_r  <= 1'b0;
		end else if (link.sck_rise && bitcnt_r == 6'h07) begin
			ignore_r  <= (mode_r == sfps_pkg::SFPS_PWRUP) || pend_rel_r;
			is_prot_r <= is_protect_op(opcode_nxt) && !busy_r
				&& (mode_r == sfps_pkg::SFPS_STANDBY) && !pend_rel_r;
			is_rel_r  <= (opcode_nxt == OP_RELEASE) && !busy_r
				&& (mode_r != sfps_pkg::SFPS_PWRUP) && !pend_rel_r;
		end else if (link.sck_rise) begin
			is_prot_r <= 1'b0;
		end
	end

	// protect armed only on a rise straight after bit eight.
	assign prot_arm = link.cs_rise && is_prot_r && !ignore_r
		&& bitcnt_r == 6'h08;
	// release armed on any rise after the opcode.
	assign rel_arm  = link.cs_rise && is_rel_r && !ignore_r;

	// signature output after dummy bytes, on falling edges.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sigbit_r   <= 3'h7;
			out_en_r   <= 1'b0;
			so_r       <= 1'b0;
			sig_done_r <= 1'b0;
		end else if (!link.cs_low) begin
			sigbit_r   <= 3'h7;
			out_en_r   <= 1'b0;
			so_r       <= 1'b0;
			sig_done_r <= 1'b0;
		end else if (link.sck_fall && is_rel_r && !ignore_r
				&& bitcnt_r >= 6'(8 * (sfps_pkg::DUMMY_BYTES + 1))) begin
			out_en_r <= 1'b1;
			so_r     <= SIGNATURE[sigbit_r];
			sigbit_r <= sigbit_r - 3'h1;
			if (sigbit_r == 3'h0) begin
				sig_done_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			mode_r       <= sfps_pkg::SFPS_PWRUP;
			pend_sleep_r <= 1'b0;
			pend_rel_r   <= 1'b0;
		end else begin
			if (prot_arm) begin
				pend_sleep_r <= 1'b1;
			end else if (sl_done) begin
				pend_sleep_r <= 1'b0;
			end
			if (rel_arm) begin
				pend_rel_r <= 1'b1;
			end else if (rl_done) begin
				pend_rel_r <= 1'b0;
			end
			unique case (mode_r)
				sfps_pkg::SFPS_PWRUP: begin
					if (pu_done) begin
						mode_r <= sfps_pkg::SFPS_STANDBY;
					end
				end
				sfps_pkg::SFPS_STANDBY: begin
					if (sl_done && pend_sleep_r) begin
						mode_r <= sfps_pkg::SFPS_PROTECTED;
					end
				end
				sfps_pkg::SFPS_PROTECTED: begin
					if (rl_done && pend_rel_r) begin
						mode_r <= sfps_pkg::SFPS_STANDBY;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			write_enable_latch <= 1'b0;
		end else if (wel_clear) begin
			write_enable_latch <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			write_in_progress <= 1'b0;
		end else begin
			write_in_progress <= busy_r;
		end
	end

	assign so             = so_r;
	assign so_oe_n        = ~out_en_r;
	assign protected_mode = (mode_r == sfps_pkg::SFPS_PROTECTED);
	assign standby        = (mode_r == sfps_pkg::SFPS_STANDBY)
		&& !pend_rel_r && !pend_sleep_r && !sl_busy && !rl_busy;
	assign cmd_enable     = (mode_r == sfps_pkg::SFPS_STANDBY)
		&& !pu_busy && !pend_rel_r;
endmodule // sfps_top
`default_nettype wire
